// File: hdl/aadf_pkg.sv
package aadf_pkg;

    // Register indices; byte address is four times the index
    localparam logic [5:0] AADF_IDX_INPUT_SEL = 6'h16;
    localparam logic [5:0] AADF_IDX_CONFIG = 6'h17;
    localparam logic [5:0] AADF_IDX_STATUS = 6'h18;
    localparam logic [5:0] AADF_IDX_RESULT = 6'h19;

    // Reset values
    localparam logic [7:0] AADF_RST_INPUT_SEL = 8'h01;
    localparam logic [7:0] AADF_RST_CONFIG = 8'h00;

    // Field positions
    localparam int AADF_NEG_LSB = 0;
    localparam int AADF_POS_LSB = 4;
    localparam int AADF_RATE_LSB = 0;
    localparam int AADF_GAIN_LSB = 2;
    localparam int AADF_REF_LSB = 5;
    localparam int AADF_ST_OVR = 0;
    localparam int AADF_ST_AVAIL = 1;
    localparam int AADF_ST_STAGE2 = 2;

    // Data rate codes
    typedef enum logic [1:0] {
        AADF_RATE_10 = 2'h0,
        AADF_RATE_100 = 2'h1,
        AADF_RATE_400 = 2'h2,
        AADF_RATE_800 = 2'h3
    } aadf_rate_t;

    // Reference source codes
    typedef enum logic [2:0] {
        AADF_REF_AIN01 = 3'h0,
        AADF_REF_AIN23 = 3'h1,
        AADF_REF_AIN45 = 3'h2,
        AADF_REF_INT = 3'h3,
        AADF_REF_SUPPLY = 3'h4
    } aadf_ref_t;

    // Modulator sample divider and gain split
    localparam logic [7:0] AADF_MOD_DIV = 8'h90;
    localparam logic [2:0] AADF_GAIN_AMP_MIN = 3'h3;
    localparam logic [1:0] AADF_MOD_GAIN_MAX = 2'h2;

    // Sinc3 decimation counts minus one and alignment shifts
    localparam logic [8:0] AADF_DEC64_M1 = 9'h03F;
    localparam logic [8:0] AADF_DEC128_M1 = 9'h07F;
    localparam logic [8:0] AADF_DEC512_M1 = 9'h1FF;
    localparam logic [3:0] AADF_SH64 = 4'h9;
    localparam logic [3:0] AADF_SH128 = 4'h6;
    localparam logic [3:0] AADF_SH512 = 4'h0;

    // Widths and second stage ratio
    localparam int AADF_RES_W = 24;
    localparam int AADF_ACC_W = 28;
    localparam logic [3:0] AADF_S2_DEC = 4'hA;
    // Third output still sees the cleared integrator history, so it is dropped too
    localparam logic [1:0] AADF_SETTLE_DROP = 2'h3;

endpackage

// File: hdl/aadf_sinc3.sv
`timescale 1ns/1ns
`default_nettype none
module aadf_sinc3 (
    input wire logic sys_clk,
    input wire logic sys_rst,
    input wire logic restart,
    input wire logic in_en,
    input wire logic in_bit,
    input wire logic [1:0] rate_code,
    output logic out_valid,
    output logic [aadf_pkg::AADF_RES_W-1:0] out_data
);
    import aadf_pkg::*;

    localparam int W = AADF_ACC_W;
    logic [W-1:0] i1_q, i2_q, i3_q; // Integrators
    logic [W-1:0] z1_q, z2_q, z3_q; // Comb delays
    logic [8:0] dcnt_q; // Decimation counter
    logic [8:0] dec_m1; // Selected ratio minus one
    logic [3:0] sh; // Alignment to full scale
    logic [W-1:0] c1, c2, c3, v27;
    logic signed [W-1:0] x;
    logic signed [W-4:0] y;
    logic dlast;

    // Ratio by rate code; 10 and 100 SPS both use 512
    always_comb begin
        case (aadf_rate_t'(rate_code))
            AADF_RATE_800: begin
                dec_m1 = AADF_DEC64_M1;
                sh = AADF_SH64;
            end
            AADF_RATE_400: begin
                dec_m1 = AADF_DEC128_M1;
                sh = AADF_SH128;
            end
            default: begin
                dec_m1 = AADF_DEC512_M1;
                sh = AADF_SH512;
            end
        endcase
    end

    assign dlast = (dcnt_q == dec_m1);
    assign c1 = i3_q - z1_q;
    assign c2 = c1 - z2_q;
    assign c3 = c2 - z3_q;
    // Scale to 2^27 full scale, center, keep 24 bits
    assign v27 = c3 << sh;
    assign x = $signed(v27 - (28'h0000001 << 26));
    assign y = 25'(x >>> 3);

    // Three integrators at modulator rate; wrap is harmless
    always_ff @(posedge sys_clk) begin
        if (sys_rst || restart) begin
            i1_q <= '0;
            i2_q <= '0;
            i3_q <= '0;
        end else if (in_en) begin
            i1_q <= i1_q + {{(W-1){1'b0}}, in_bit};
            i2_q <= i2_q + i1_q;
            i3_q <= i3_q + i2_q;
        end
    end

    // Decimation counter
    always_ff @(posedge sys_clk) begin
        if (sys_rst || restart || (in_en && dlast)) begin
            dcnt_q <= '0;
        end else if (in_en) begin
            dcnt_q <= dcnt_q + 9'h001;
        end
    end

    // Combs at output rate, with saturation of top code
    always_ff @(posedge sys_clk) begin
        if (sys_rst || restart) begin
            z1_q <= '0;
            z2_q <= '0;
            z3_q <= '0;
            out_valid <= 1'b0;
            out_data <= '0;
        end else begin
            out_valid <= in_en && dlast;
            if (in_en && dlast) begin
                z1_q <= i3_q;
                z2_q <= c1;
                z3_q <= c2;
                if (y[W-4] == 1'b0 && y[W-5] == 1'b1) begin
                    out_data <= 24'h7FFFFF;
                end else begin
                    out_data <= y[AADF_RES_W-1:0];
                end
            end
        end
    end
endmodule
`default_nettype wire

// File: hdl/aadf_skid.sv
`timescale 1ns/1ns
`default_nettype none
module aadf_skid #(
    parameter int W = 25,
    parameter int D = 2
) (
    input wire logic sys_clk,
    input wire logic sys_rst,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [W-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [W-1:0] out_data
);
    localparam int CW = $clog2(D + 1);
    logic [W-1:0] mem_q [D]; // Entry 0 is the head
    logic [D-1:0] vld_q; // Per-entry valid
    logic [CW-1:0] cnt; // Occupancy
    logic [CW-1:0] wpos; // Write slot after any pop
    logic push, pop;

    // Count valid entries
    always_comb begin
        cnt = '0;
        for (int k = 0; k < D; k++) begin
            cnt = cnt + CW'(vld_q[k]);
        end
    end

    assign pop = vld_q[0] & out_ready;
    assign in_ready = ~vld_q[D-1] | out_ready;
    assign push = in_valid & in_ready;
    assign wpos = pop ? cnt - CW'(1) : cnt;
    assign out_valid = vld_q[0];
    assign out_data = mem_q[0];

    // Shift toward the head on pop, write at tail on push
    for (genvar i = 0; i < D; i++) begin : g_ent
        logic nv;
        logic [W-1:0] nd;
        if (i < D - 1) begin : g_mid
            assign nv = vld_q[i+1];
            assign nd = mem_q[i+1];
        end else begin : g_end
            assign nv = 1'b0;
            assign nd = mem_q[i];
        end
        always_ff @(posedge sys_clk) begin
            if (sys_rst) begin
                vld_q[i] <= 1'b0;
                mem_q[i] <= '0;
            end else if (push && wpos == CW'(i)) begin
                vld_q[i] <= 1'b1;
                mem_q[i] <= in_data;
            end else if (pop) begin
                vld_q[i] <= nv;
                mem_q[i] <= nd;
            end
        end
    end
endmodule
`default_nettype wire

// File: hdl/aadf_top.sv
`timescale 1ns/1ns
`default_nettype none
module aadf_top (
    input wire logic sys_clk,
    input wire logic sys_rst,
    // Wishbone classic slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // Modulator side
    input wire logic mod_bit_i,
    output logic mod_sample_o,
    output logic [3:0] aux_pos_channel_o,
    output logic [3:0] aux_neg_channel_o,
    output logic amp_bypass_o,
    output logic [1:0] mod_gain_o,
    output logic [2:0] amp_gain_o,
    output logic [4:0] ref_sel_o,
    // Result stream
    output logic [aadf_pkg::AADF_RES_W-1:0] res_data_o,
    output logic res_stage2_o,
    output logic res_valid_o,
    input wire logic res_ready_i
);
    import aadf_pkg::*;

    // Bus side
    logic ack_q; // Acknowledge
    logic [31:0] dat_q; // Read data
    logic req; // New bus request
    logic [5:0] idx; // Word index
    logic wr_lo; // Write to low byte lane

    // Register state
    logic [7:0] mux_q; // Input selection
    logic [7:0] cfg_q; // Gain, rate, reference
    logic ovr_q; // Sticky overrun
    logic restart_q; // Filter restart pulse
    logic [AADF_RES_W:0] last_q; // Newest result and flag

    // Decoded front end controls
    logic bypass_q;
    logic [1:0] mgain_q;
    logic [2:0] again_q;
    logic [4:0] ref_q;

    // Modulator timing and input capture
    logic [7:0] div_q; // Master clock divider
    logic smp_q; // Sample enable
    logic s1_q, s2_q, s3_q; // Pin synchroniser
    logic bit_q; // Accepted modulator bit

    // Filter chain
    logic s3_vld; // Sinc3 result pulse
    logic [AADF_RES_W-1:0] s3_dat;
    logic [1:0] drop_q; // Settling outputs to discard
    logic kept; // Settled sinc3 result
    logic stage2_on; // Second stage active
    logic signed [AADF_ACC_W-1:0] acc_q; // Sinc1 accumulator
    logic signed [AADF_ACC_W-1:0] sum;
    logic signed [AADF_ACC_W-1:0] avg;
    logic [3:0] n_q; // Sinc1 input count
    logic flt_vld_q; // Filter result pulse
    logic flt_s2_q; // Result came through stage two
    logic [AADF_RES_W-1:0] flt_dat_q;
    logic buf_rdy; // Buffer can take a word

    assign req = wb_cyc_i & wb_stb_i & ~ack_q;
    assign idx = wb_adr_i[7:2];
    assign wr_lo = req & wb_we_i & wb_sel_i[0];
    assign wb_ack_o = ack_q;
    assign wb_dat_o = dat_q;

    // One acknowledge per request, one cycle after it is seen
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            ack_q <= 1'b0;
        end else begin
            ack_q <= req;
        end
    end

    // Read mux; unmapped indices read zero
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            dat_q <= '0;
        end else if (req && !wb_we_i) begin
            case (idx)
                AADF_IDX_INPUT_SEL: dat_q <= {24'h000000, mux_q};
                AADF_IDX_CONFIG: dat_q <= {24'h000000, cfg_q};
                AADF_IDX_STATUS: begin
                    dat_q <= '0;
                    dat_q[AADF_ST_OVR] <= ovr_q;
                    dat_q[AADF_ST_AVAIL] <= res_valid_o;
                    dat_q[AADF_ST_STAGE2] <= stage2_on;
                end
                AADF_IDX_RESULT: dat_q <= {7'h00, last_q};
                default: dat_q <= '0;
            endcase
        end
    end

    // Input selection register
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            mux_q <= AADF_RST_INPUT_SEL;
        end else if (wr_lo && idx == AADF_IDX_INPUT_SEL) begin
            mux_q <= wb_dat_i[7:0];
        end
    end

    // Configuration register; rate resets to 10 SPS
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            cfg_q <= AADF_RST_CONFIG;
        end else if (wr_lo && idx == AADF_IDX_CONFIG) begin
            cfg_q <= wb_dat_i[7:0];
        end
    end

    // Any selection change restarts the filter
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            restart_q <= 1'b0;
        end else begin
            restart_q <= wr_lo && (idx == AADF_IDX_INPUT_SEL || idx == AADF_IDX_CONFIG);
        end
    end

    // Overrun flag; a new overrun wins over a clear
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            ovr_q <= 1'b0;
        end else if (flt_vld_q && !buf_rdy) begin
            ovr_q <= 1'b1;
        end else if (wr_lo && idx == AADF_IDX_STATUS && wb_dat_i[AADF_ST_OVR]) begin
            ovr_q <= 1'b0;
        end
    end

    // Channel fields go straight to the input multiplexer
    assign aux_pos_channel_o = mux_q[AADF_POS_LSB +: 4];
    assign aux_neg_channel_o = mux_q[AADF_NEG_LSB +: 4];

    // Gain split: modulator takes up to 4, amplifier the rest
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            bypass_q <= 1'b1;
            mgain_q <= '0;
            again_q <= '0;
        end else if (cfg_q[AADF_GAIN_LSB +: 3] < AADF_GAIN_AMP_MIN) begin
            bypass_q <= 1'b1;
            mgain_q <= cfg_q[AADF_GAIN_LSB +: 2];
            again_q <= '0;
        end else begin
            bypass_q <= 1'b0;
            mgain_q <= AADF_MOD_GAIN_MAX;
            again_q <= cfg_q[AADF_GAIN_LSB +: 3] - 3'h2;
        end
    end

    assign amp_bypass_o = bypass_q;
    assign mod_gain_o = mgain_q;
    assign amp_gain_o = again_q;

    // One-hot reference select; unused codes fall to internal
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            ref_q <= 5'h08;
        end else begin
            case (aadf_ref_t'(cfg_q[AADF_REF_LSB +: 3]))
                AADF_REF_AIN01: ref_q <= 5'h01;
                AADF_REF_AIN23: ref_q <= 5'h02;
                AADF_REF_AIN45: ref_q <= 5'h04;
                AADF_REF_SUPPLY: ref_q <= 5'h10;
                default: ref_q <= 5'h08;
            endcase
        end
    end

    assign ref_sel_o = ref_q;

    // Sample enable every 144 master clocks; rates follow clock
    always_ff @(posedge sys_clk) begin
        if (sys_rst || div_q == AADF_MOD_DIV - 8'h01) begin
            div_q <= '0;
        end else begin
            div_q <= div_q + 8'h01;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            smp_q <= 1'b0;
        end else begin
            smp_q <= (div_q == AADF_MOD_DIV - 8'h01);
        end
    end

    assign mod_sample_o = smp_q;

    // Three-stage capture of the modulator bit
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            s1_q <= 1'b0;
            s2_q <= 1'b0;
            s3_q <= 1'b0;
        end else begin
            s1_q <= mod_bit_i;
            s2_q <= s1_q;
            s3_q <= s2_q;
        end
    end

    // Accept a change only once two stages agree
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            bit_q <= 1'b0;
        end else if (s2_q == s3_q) begin
            bit_q <= s3_q;
        end
    end

    // First stage
    aadf_sinc3 u_sinc3 (
        .sys_clk(sys_clk),
        .sys_rst(sys_rst),
        .restart(restart_q),
        .in_en(smp_q),
        .in_bit(bit_q),
        .rate_code(cfg_q[AADF_RATE_LSB +: 2]),
        .out_valid(s3_vld),
        .out_data(s3_dat)
    );

    // Drop partial results while the sinc3 settles
    always_ff @(posedge sys_clk) begin
        if (sys_rst || restart_q) begin
            drop_q <= AADF_SETTLE_DROP;
        end else if (s3_vld && drop_q != 2'h0) begin
            drop_q <= drop_q - 2'h1;
        end
    end

    assign kept = s3_vld && drop_q == 2'h0;
    // Stage two only at the 10 SPS code
    assign stage2_on = (cfg_q[AADF_RATE_LSB +: 2] == AADF_RATE_10);
    assign sum = acc_q + AADF_ACC_W'(signed'(s3_dat));
    assign avg = sum / 28'sd10;

    // Sinc1: sum ten 100 SPS inputs, ratio 512 times 10
    always_ff @(posedge sys_clk) begin
        if (sys_rst || restart_q) begin
            acc_q <= '0;
            n_q <= '0;
        end else if (kept && stage2_on) begin
            if (n_q == AADF_S2_DEC - 4'h1) begin
                acc_q <= '0;
                n_q <= '0;
            end else begin
                acc_q <= sum;
                n_q <= n_q + 4'h1;
            end
        end
    end

    // Result strobe from whichever stage is last
    always_ff @(posedge sys_clk) begin
        if (sys_rst || restart_q) begin
            flt_vld_q <= 1'b0;
            flt_s2_q <= 1'b0;
            flt_dat_q <= '0;
        end else if (stage2_on) begin
            flt_vld_q <= kept && n_q == AADF_S2_DEC - 4'h1;
            flt_s2_q <= 1'b1;
            flt_dat_q <= avg[AADF_RES_W-1:0];
        end else begin
            flt_vld_q <= kept;
            flt_s2_q <= 1'b0;
            flt_dat_q <= s3_dat;
        end
    end

    // Newest result kept for register readout
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            last_q <= '0;
        end else if (flt_vld_q) begin
            last_q <= {flt_s2_q, flt_dat_q};
        end
    end

    // Two-entry buffer toward the consumer
    aadf_skid #(
        .W(AADF_RES_W + 1),
        .D(2)
    ) u_skid (
        .sys_clk(sys_clk),
        .sys_rst(sys_rst),
        .in_valid(flt_vld_q),
        .in_ready(buf_rdy),
        .in_data({flt_s2_q, flt_dat_q}),
        .out_valid(res_valid_o),
        .out_ready(res_ready_i),
        .out_data({res_stage2_o, res_data_o})
    );
endmodule
`default_nettype wire

// File: verification/aadf_asserts.sv
`timescale 1ns/1ns
`default_nettype none
module aadf_asserts (
    input wire logic sys_clk,
    input wire logic sys_rst,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic wb_ack_o,
    input wire logic mod_sample_o,
    input wire logic [3:0] aux_pos_channel_o,
    input wire logic [3:0] aux_neg_channel_o,
    input wire logic amp_bypass_o,
    input wire logic [1:0] mod_gain_o,
    input wire logic [2:0] amp_gain_o,
    input wire logic [4:0] ref_sel_o,
    input wire logic [aadf_pkg::AADF_RES_W-1:0] res_data_o,
    input wire logic res_stage2_o,
    input wire logic res_valid_o,
    input wire logic res_ready_i
);
    import aadf_pkg::*;
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (sys_rst);
    logic [7:0] gap_q; // Cycles since the last sample pulse
    logic seen_q; // A pulse has been seen since the last write or reset
    logic wr_d_q; // Write acknowledged one cycle ago
    logic [7:0] sel_q; // Last input select value written
    logic [7:0] cfg_q; // Last config value written
    // Sample pulse spacing counter
    always_ff @(posedge sys_clk) begin
        if (sys_rst || mod_sample_o) gap_q <= 8'h00;
        else gap_q <= gap_q + 8'h01;
    end
    // Writes never restart the divider, yet spacing is only judged after a fresh pulse that follows any write
    always_ff @(posedge sys_clk) begin
        wr_d_q <= !sys_rst && wb_ack_o && wb_we_i;
        if (sys_rst || (wb_ack_o && wb_we_i) || wr_d_q) seen_q <= 1'b0;
        else if (mod_sample_o) seen_q <= 1'b1;
    end
    // Shadow copies of written registers
    always_ff @(posedge sys_clk) begin
        if (wb_ack_o && wb_we_i && wb_sel_i[0] && wb_adr_i == 8'h58) sel_q <= wb_dat_i[7:0];
        if (wb_ack_o && wb_we_i && wb_sel_i[0] && wb_adr_i == 8'h5C) cfg_q <= wb_dat_i[7:0];
    end
    sequence s_wr(logic [7:0] a);
        wb_ack_o && wb_cyc_i && wb_stb_i && wb_we_i && wb_sel_i[0] && wb_adr_i == a;
    endsequence
    sequence s_req;
        wb_cyc_i && wb_stb_i && !wb_ack_o;
    endsequence
    property p_pos_chan;
        s_wr(8'h58) |-> ##3 aux_pos_channel_o == sel_q[7:4];
    endproperty
    a_pos_chan: assert property (p_pos_chan) else $error("positive channel wrong");
    property p_neg_chan;
        s_wr(8'h58) |-> ##3 aux_neg_channel_o == sel_q[3:0];
    endproperty
    a_neg_chan: assert property (p_neg_chan) else $error("negative channel wrong");
    property p_bypass;
        s_wr(8'h5C) |-> ##3 amp_bypass_o == (cfg_q[4:2] < 3'h3);
    endproperty
    a_bypass: assert property (p_bypass) else $error("amplifier bypass wrong");
    property p_gain;
        s_wr(8'h5C) |-> ##3 ({1'b0, mod_gain_o} + amp_gain_o) == cfg_q[4:2];
    endproperty
    a_gain: assert property (p_gain) else $error("gain split wrong");
    property p_ref;
        s_wr(8'h5C) |-> ##3 ref_sel_o == ((cfg_q[7:5] > 3'h4) ? 5'h08 : (5'h01 << cfg_q[7:5]));
    endproperty
    a_ref: assert property (p_ref) else $error("reference select wrong");
    property p_ref_onehot;
        $onehot(ref_sel_o);
    endproperty
    a_ref_onehot: assert property (p_ref_onehot) else $error("reference not one-hot");
    property p_mod_rate;
        mod_sample_o && seen_q |-> gap_q == 8'h8F;
    endproperty
    a_mod_rate: assert property (p_mod_rate) else $error("sample pulse spacing wrong");
    property p_res_hold;
        res_valid_o && !res_ready_i |=> res_valid_o && $stable(res_data_o) && $stable(res_stage2_o);
    endproperty
    a_res_hold: assert property (p_res_hold) else $error("result lost under stall");
    property p_ack;
        s_req |=> wb_ack_o ##1 !wb_ack_o;
    endproperty
    a_ack: assert property (p_ack) else $error("bus answer timing wrong");
endmodule
bind aadf_top aadf_asserts chk_u (.sys_clk, .sys_rst, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
    .wb_sel_i, .wb_dat_i, .wb_ack_o, .mod_sample_o, .aux_pos_channel_o, .aux_neg_channel_o,
    .amp_bypass_o, .mod_gain_o, .amp_gain_o, .ref_sel_o, .res_data_o, .res_stage2_o,
    .res_valid_o, .res_ready_i);
`default_nettype wire

// File: verification/aadf_mod_model.sv
`timescale 1ns/1ns
`default_nettype none
module aadf_mod_model (
    input wire logic sys_clk,
    input wire logic sys_rst,
    input wire logic mod_sample_o,
    input wire logic [1:0] density,
    output logic mod_bit_i
);
    logic alt_q; // Phase for the half-density pattern
    // New bit on every sample pulse: 0 all ones, 1 all zeros, else alternating
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            mod_bit_i <= 1'b0;
            alt_q <= 1'b0;
        end else if (mod_sample_o) begin
            alt_q <= !alt_q;
            mod_bit_i <= (density == 2'h0) ? 1'b1 : (density == 2'h1) ? 1'b0 : alt_q;
        end
    end
endmodule
`default_nettype wire

// File: verification/aadf_top_tb.sv
`timescale 1ns/1ns
`default_nettype none
module aadf_top_tb;
    import aadf_pkg::*;
    logic sys_clk, sys_rst, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, mod_bit_i, mod_sample_o;
    logic [7:0] wb_adr_i;
    logic [3:0] wb_sel_i, aux_pos_channel_o, aux_neg_channel_o;
    logic [31:0] wb_dat_i, wb_dat_o;
    logic amp_bypass_o, res_stage2_o, res_valid_o, res_ready_i;
    logic [1:0] mod_gain_o, dens;
    logic [2:0] amp_gain_o;
    logic [4:0] ref_sel_o;
    logic [AADF_RES_W-1:0] res_data_o;
    int n_fail = 0;
    int cmp_count = 0;
    integer seed = 3864;
    logic rd_chk; // Current read is to be compared
    logic [31:0] exp_rd[$]; // Expected read data
    logic [24:0] exp_res[$]; // Expected stream words, flag above data
    aadf_top dut_u (.sys_clk, .sys_rst, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i,
        .wb_dat_i, .wb_dat_o, .wb_ack_o, .mod_bit_i, .mod_sample_o, .aux_pos_channel_o,
        .aux_neg_channel_o, .amp_bypass_o, .mod_gain_o, .amp_gain_o, .ref_sel_o, .res_data_o,
        .res_stage2_o, .res_valid_o, .res_ready_i);
    aadf_mod_model mod_u (.sys_clk, .sys_rst, .mod_sample_o, .density(dens), .mod_bit_i);
    // Clock, 100 ns period
    initial begin
        sys_clk = 1'b0;
        forever #50 sys_clk = ~sys_clk;
    end
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            n_fail++;
            $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wrap_up();
        $display("Comparisons %0d, mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    // One classic cycle; holds everything until ack is sampled
    task automatic bus(input logic we, input logic [7:0] a, input logic [31:0] d,
                       input logic [3:0] s, input logic c, output logic [31:0] q);
        int n;
        n = 0;
        @(posedge sys_clk);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= a;
        wb_dat_i <= d;
        wb_sel_i <= s;
        rd_chk <= c;
        do begin
            @(posedge sys_clk);
            n++;
        end while (wb_ack_o !== 1'b1 && n < 20);
        if (wb_ack_o !== 1'b1) begin
            n_fail++;
            $display("CHECK FAILED at %0t: no bus answer", $time);
        end
        q = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        wb_we_i <= 1'b0;
        rd_chk <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        bus(1'b1, a, d, 4'hF, 1'b0, q);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        logic [31:0] q;
        exp_rd.push_back(e);
        bus(1'b0, a, 32'h0, 4'hF, 1'b1, q);
    endtask
    // Output watcher: takes the oldest note whenever a checked read is answered or a result is taken
    always @(posedge sys_clk) begin
        if (wb_ack_o === 1'b1 && rd_chk === 1'b1) begin
            chk(wb_dat_o, exp_rd.pop_front());
        end
        if (res_valid_o === 1'b1 && res_ready_i === 1'b1) begin
            chk({7'h0, res_stage2_o, res_data_o}, {7'h0, exp_res.pop_front()});
        end
    end
    // Main sequence
    initial begin
        logic [31:0] q, v;
        logic [3:0] i;
        int n;
        sys_rst = 1'b1;
        wb_cyc_i = 1'b0;
        wb_stb_i = 1'b0;
        wb_we_i = 1'b0;
        wb_adr_i = 8'h00;
        wb_sel_i = 4'h0;
        wb_dat_i = 32'h0;
        res_ready_i = 1'b0;
        dens = 2'h0;
        rd_chk = 1'b0;
        repeat (12) @(posedge sys_clk);
        sys_rst <= 1'b0;
        rd(8'h58, {24'h0, AADF_RST_INPUT_SEL});
        rd(8'h5C, 32'h0);
        rd(8'h60, 32'h4);
        wr(8'h00, 32'hFF);
        rd(8'h00, 32'h0);
        v = $random(seed);
        wr(8'h58, v);
        rd(8'h58, {24'h0, v[7:0]});
        bus(1'b1, 8'h58, ~v, 4'hE, 1'b0, q);
        rd(8'h58, {24'h0, v[7:0]});
        // Every gain, rate and reference code; stage two only at the slowest rate
        for (i = 4'h0; i < 4'h8; i++) begin
            v = {24'h0, i[2:0], ~i[2:0], i[1:0]};
            wr(8'h5C, v);
            rd(8'h5C, v);
            rd(8'h60, {29'h0, i[1:0] == 2'h0, 2'h0});
        end
        // Full-scale positive input at the fastest rate, consumer stalled
        exp_res.push_back(25'h07FFFFF);
        exp_res.push_back(25'h07FFFFF);
        wr(8'h5C, 32'h63);
        n = 0;
        do begin
            repeat (500) @(posedge sys_clk);
            bus(1'b0, 8'h60, 32'h0, 4'hF, 1'b0, q);
            n++;
        end while (q[0] !== 1'b1 && n < 120);
        rd(8'h60, 32'h3);
        rd(8'h64, 32'h007FFFFF);
        res_ready_i <= 1'b1;
        n = 0;
        while (exp_res.size() != 0 && n < 100) begin
            @(posedge sys_clk);
            n++;
        end
        // Full-scale negative input after a restart
        dens <= 2'h1;
        exp_res.push_back(25'h0800000);
        wr(8'h5C, 32'h63);
        wr(8'h60, 32'h1);
        rd(8'h60, 32'h0);
        n = 0;
        while (exp_res.size() != 0 && n < 40000) begin
            @(posedge sys_clk);
            n++;
        end
        chk(exp_res.size(), 32'h0);
        wrap_up();
    end
    // Watchdog against a hang
    initial begin
        #(100 * 99000);
        n_fail++;
        wrap_up();
    end
endmodule
`default_nettype wire
